// ---- hdl/sms_defines.svh ----
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

// Register offsets on the plain register port
`define SMS_ADDR_CTRL   8'h2c
`define SMS_ADDR_STAT   8'h2d
`define SMS_ADDR_DATA   8'h2e

// Control register fields
`define SMS_CTRL_XIE    7
`define SMS_CTRL_ON     6
`define SMS_CTRL_ORDER  5
`define SMS_CTRL_MS     4
`define SMS_CTRL_CPOL   3
`define SMS_CTRL_CPHA   2
`define SMS_CTRL_RHI    1
`define SMS_CTRL_RLO    0
`define SMS_CTRL_RST    8'h00

// Status register fields
`define SMS_STAT_DONE   7
`define SMS_STAT_CLASH  6
`define SMS_STAT_DBL    0
`define SMS_STAT_RST    8'h00

// System clocks per serial clock, indexed by {double, hi, lo}
`define SMS_DIV_0       8'h04
`define SMS_DIV_1       8'h10
`define SMS_DIV_2       8'h40
`define SMS_DIV_3       8'h80
`define SMS_DIV_4       8'h02
`define SMS_DIV_5       8'h08
`define SMS_DIV_6       8'h20
`define SMS_DIV_7       8'h40

// Sixteen serial clock edges make one byte
`define SMS_LAST_EDGE   4'hf

`endif

// ---- hdl/sms_pkg.sv ----
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_IDLE = 2'b01,
    SMS_RUN  = 2'b10
  } sms_state_t;

  typedef logic [7:0] sms_byte_t;

endpackage : sms_pkg

// ---- hdl/sms_clk_div.sv ----
`timescale 1ns/1ps
`include "sms_defines.svh"

module sms_clk_div
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       clr_i,
  input  wire logic [2:0] rate_i,
  // Half-period strobe
  output logic            tick_o
);

  logic [7:0] div;
  logic [6:0] half;
  logic [6:0] cnt_q;

  always_comb
  begin
    unique case (rate_i)
      3'h0: div = `SMS_DIV_0;
      3'h1: div = `SMS_DIV_1;
      3'h2: div = `SMS_DIV_2;
      3'h3: div = `SMS_DIV_3;
      3'h4: div = `SMS_DIV_4;
      3'h5: div = `SMS_DIV_5;
      3'h6: div = `SMS_DIV_6;
      3'h7: div = `SMS_DIV_7;
    endcase
    half = div[7:1];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (clr_i)
    begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (cnt_q == half - 7'h01)
    begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 7'h01;
      tick_o <= 1'b0;
    end
  end

  a_tick_spacing : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick_o && !clr_i && half != 7'h01) |=> !tick_o)
    else $error("tick strobes too close for the selected rate");

  a_fast_rate : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!clr_i && rate_i == 3'h4 && $past(!clr_i && rate_i == 3'h4)) |=> tick_o)
    else $error("fastest rate does not tick every cycle");

endmodule : sms_clk_div

// ---- hdl/sms_port.sv ----
`timescale 1ns/1ps
`include "sms_defines.svh"


module sms_port
  import sms_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Register port
  input  wire logic [7:0]      addr_i,
  input  wire sms_pkg::sms_byte_t wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output sms_pkg::sms_byte_t   rdata_o,
  // Interrupt
  input  wire logic            gie_i,
  input  wire logic            irq_ack_i,
  output logic                 irq_o,
  // Software pin directions, one means output
  input  wire logic            sck_dir_i,
  input  wire logic            mosi_dir_i,
  input  wire logic            miso_dir_i,
  input  wire logic            ss_dir_i,
  // Serial pins
  input  wire logic            sck_i,
  output logic                 sck_o,
  output logic                 sck_oe_o,
  input  wire logic            mosi_i,
  output logic                 mosi_o,
  output logic                 mosi_oe_o,
  input  wire logic            miso_i,
  output logic                 miso_o,
  output logic                 miso_oe_o,
  input  wire logic            ss_n_i
);
  import sms_pkg::*;

  sms_byte_t  ctrl_q;
  sms_byte_t  sh_q;
  sms_byte_t  rx_q;
  sms_byte_t  sh_next;
  sms_state_t state_q;
  logic [3:0] cnt_q;
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       sck_s3_q;
  logic       xfer_done_flag_q;
  logic       write_clash_flag_q;
  logic       dbl_q;
  logic       arm_xfer_done_flag_q;
  logic       arm_write_clash_flag_q;
  logic       out_q;
  logic       out_d;
  logic       tick;
  logic       on;
  logic       ms;
  logic       cpha;
  logic       lsb_first;
  logic       ss_s;
  logic       sck_s;
  logic       mosi_s;
  logic       slave_act;
  logic       fault;
  logic       busy;
  logic       m_edge;
  logic       s_edge;
  logic       lead;
  logic       edge_ev;
  logic       sample;
  logic       setup;
  logic       done;
  logic       din;
  logic       top;
  logic       wr_ctrl;
  logic       wr_data;
  logic       rd_stat;
  logic       data_acc;
  logic       start;

  assign on        = ctrl_q[`SMS_CTRL_ON];
  assign ms        = ctrl_q[`SMS_CTRL_MS];
  assign cpha      = ctrl_q[`SMS_CTRL_CPHA];
  assign lsb_first = ctrl_q[`SMS_CTRL_ORDER];

  assign wr_ctrl  = wr_i && addr_i == `SMS_ADDR_CTRL;
  assign wr_data  = wr_i && addr_i == `SMS_ADDR_DATA;
  assign rd_stat  = rd_i && addr_i == `SMS_ADDR_STAT;
  assign data_acc = (wr_i || rd_i) && addr_i == `SMS_ADDR_DATA;

  // Two-flop synchronisers for the pins the slave watches
  assign pin_raw = {ss_n_i, sck_i, mosi_i, miso_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          s1_q[g] <= 1'b1;
          s2_q[g] <= 1'b1;
        end
        else
        begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  assign ss_s   = s2_q[3];
  assign sck_s  = s2_q[2];
  assign mosi_s = s2_q[1];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sck_s3_q <= 1'b1;
    else
      sck_s3_q <= sck_s;
  end

  // Mode fault: only when the select pin is an input
  assign fault     = on && ms && !ss_dir_i && !ss_s;
  assign slave_act = on && !ms && !ss_s;
  assign busy      = state_q == SMS_RUN || (!ms && cnt_q != 4'h0);
  assign start     = wr_data && !busy && on && ms && !fault;

  // Rate bits always reach the divider; it is held clear outside SMS_RUN
  sms_clk_div u_div
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (state_q != SMS_RUN),
    .rate_i  ({dbl_q, ctrl_q[`SMS_CTRL_RHI], ctrl_q[`SMS_CTRL_RLO]}),
    .tick_o  (tick)
  );

  // Edge events; master takes an even edge count as leading, slave reads it from the clock level
  assign m_edge  = state_q == SMS_RUN && tick;
  assign s_edge  = slave_act && (sck_s != sck_s3_q);
  assign lead    = ms ? !cnt_q[0] : (sck_s ^ ctrl_q[`SMS_CTRL_CPOL]);
  assign edge_ev = m_edge || s_edge;
  assign sample  = edge_ev && (lead ^ cpha);
  assign setup   = edge_ev && !(lead ^ cpha);
  assign done    = edge_ev && cnt_q == `SMS_LAST_EDGE;

  // Master samples the pin directly; slave uses the synchronised copy
  assign din     = ms ? miso_i : mosi_s;
  assign sh_next = lsb_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};
  assign top     = lsb_first ? sh_q[0] : sh_q[7];

  // Control register; a mode fault wins over a write of the master bit
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_q <= `SMS_CTRL_RST;
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wdata_i;
      if (fault)
        ctrl_q[`SMS_CTRL_MS] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dbl_q <= 1'b0;
    else if (wr_i && addr_i == `SMS_ADDR_STAT)
      dbl_q <= wdata_i[`SMS_STAT_DBL];
  end

  // Master sequencer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= SMS_IDLE;
    else
    begin
      unique case (state_q)
        SMS_IDLE:
          if (start)
            state_q <= SMS_RUN;
        SMS_RUN:
          if (fault || !on || done)
            state_q <= SMS_IDLE;
      endcase
    end
  end

  // Edge counter, cleared when the slave is deselected or the port stops
  // Start clears it too, so slave edges seen before a role change cannot skew a byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= 4'h0;
    else if (!on || fault || start || (!ms && ss_s))
      cnt_q <= 4'h0;
    else if (edge_ev)
      cnt_q <= cnt_q + 4'h1;
  end

  // Shift register; a write during a transfer is refused
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sh_q <= 8'h00;
    else if (wr_data && !busy)
      sh_q <= wdata_i;
    else if (sample)
      sh_q <= sh_next;
  end

  // Receive buffer takes the byte only when complete, so partials are dropped
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rx_q <= 8'h00;
    else if (done)
      rx_q <= sample ? sh_next : sh_q;
  end

  // Output bit: phase 0 presents the first bit before any edge
  assign out_d = ((cnt_q == 4'h0 && !cpha && !edge_ev) || setup) ? top : out_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_q <= 1'b0;
    else
      out_q <= out_d;
  end

  // Serial clock generator; rests at the idle level
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sck_o <= 1'b0;
    else if (m_edge)
      sck_o <= ~sck_o;
    else if (state_q == SMS_IDLE)
      sck_o <= ctrl_q[`SMS_CTRL_CPOL];
  end

  // Pin drivers: slave drives only its data out, and only while selected
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_oe_o  <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      sck_oe_o  <= on && ms && !fault && sck_dir_i;
      mosi_oe_o <= on && ms && !fault && mosi_dir_i;
      miso_oe_o <= slave_act && miso_dir_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
    end
    else
    begin
      // Pins take the new bit at once; a lag would meet the next edge at /2
      mosi_o <= out_d;
      miso_o <= out_d;
    end
  end

  // Flag clear arms on a status read that saw the flag set
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      arm_xfer_done_flag_q <= 1'b0;
      arm_write_clash_flag_q <= 1'b0;
    end
    else if (rd_stat)
    begin
      arm_xfer_done_flag_q <= xfer_done_flag_q;
      arm_write_clash_flag_q <= write_clash_flag_q;
    end
    else if (data_acc)
    begin
      arm_xfer_done_flag_q <= 1'b0;
      arm_write_clash_flag_q <= 1'b0;
    end
  end

  // Set wins over clear for both flags
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      xfer_done_flag_q <= 1'b0;
    else if (done || fault)
      xfer_done_flag_q <= 1'b1;
    else if (irq_ack_i || (data_acc && arm_xfer_done_flag_q))
      xfer_done_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      write_clash_flag_q <= 1'b0;
    else if (wr_data && busy)
      write_clash_flag_q <= 1'b1;
    else if (data_acc && arm_write_clash_flag_q)
      write_clash_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= ctrl_q[`SMS_CTRL_XIE] && xfer_done_flag_q && gie_i;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        `SMS_ADDR_CTRL: rdata_o <= ctrl_q;
        `SMS_ADDR_STAT: rdata_o <= {xfer_done_flag_q, write_clash_flag_q, 5'h00, dbl_q};
        `SMS_ADDR_DATA: rdata_o <= rx_q;
        default:        rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  a_fault_to_slave : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault |=> !ctrl_q[`SMS_CTRL_MS] && xfer_done_flag_q ##1 !sck_oe_o && !mosi_oe_o)
    else $error("mode fault did not force slave role");

  a_ms_sticky : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ctrl_q[`SMS_CTRL_MS] && !wr_ctrl) |=> !ctrl_q[`SMS_CTRL_MS])
    else $error("master bit set without a write");

  a_irq_gating : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o |-> $past(gie_i) && $past(xfer_done_flag_q) && $past(ctrl_q[`SMS_CTRL_XIE]))
    else $error("interrupt raised without all enables");

  a_idle_level : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == SMS_IDLE)[*2] |-> sck_o == $past(ctrl_q[`SMS_CTRL_CPOL]))
    else $error("serial clock not at idle level");

  a_off_quiet : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !on |=> state_q == SMS_IDLE && cnt_q == 4'h0 && !miso_oe_o)
    else $error("port active while switched off");

  a_deselect_reset : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ms && ss_s) |=> cnt_q == 4'h0 && !miso_oe_o)
    else $error("slave logic not reset on deselect");

  a_clash_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_data && busy) |=> write_clash_flag_q && !$rose(state_q == SMS_RUN))
    else $error("write during transfer not flagged");

  a_done_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done |=> xfer_done_flag_q && rx_q == $past(sample ? sh_next : sh_q))
    else $error("completed byte not flagged or buffered");

  a_master_len : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (start && dbl_q && ctrl_q[1:0] == 2'h0) |-> ##[17:20] xfer_done_flag_q)
    else $error("fastest master byte did not finish in time");

  c_master_byte : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    m_edge && done);
  c_slave_byte : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    s_edge && done);
  c_mode_fault : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    fault);
  c_clash : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_data && busy);

endmodule : sms_port

// ---- tb/sms_spi_peer.sv ----
`timescale 1ns/1ps

module sms_spi_peer
(
  // Serial lines
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  output logic            miso_o,
  // Mode and data
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o
);
  int idx;

  initial
  begin
    idx = 0;
    rx_o = 8'h00;
    miso_o = 1'b0;
  end

  // Phase 1 waits for the leading edge before its first bit
  always @(negedge sel_n_i)
  begin
    idx = cpha_i ? -1 : 0;
    rx_o = 8'h00;
  end

  always @(sck_i)
  begin
    if (!sel_n_i && ((sck_i != cpol_i) ^ cpha_i))
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
    else if (!sel_n_i)
      idx = idx + 1;
  end

  // Released line keeps changing so a stale bit cannot pass
  always @(sel_n_i or idx or sck_i)
  begin
    if (sel_n_i)
      miso_o = ~miso_o;
    else if (idx >= 0 && idx < 8)
      miso_o = tx_i[lsb_i ? idx : 7 - idx];
  end
endmodule : sms_spi_peer

// ---- tb/test_spi_master_slave_port.sv ----
`timescale 1ns/1ps
`include "sms_defines.svh"

module test_spi_master_slave_port;
  import sms_pkg::*;

  logic       clk_i, rst_n_i, wr_i, rd_i, gie_i, irq_ack_i, irq_o, ss_n_i;
  logic       sck_dir_i, mosi_dir_i, miso_dir_i, ss_dir_i;
  logic       sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic       tb_sck, tb_mosi, peer_miso, peer_sel_n, peer_cpol, peer_cpha, peer_lsb;
  logic [7:0] addr_i, peer_tx, peer_rx;
  sms_byte_t  wdata_i, rdata_o;
  wire        sck_w  = sck_oe_o ? sck_o : tb_sck;
  wire        mosi_w = mosi_oe_o ? mosi_o : tb_mosi;
  wire        miso_w = miso_oe_o ? miso_o : peer_miso;
  int         error_cnt, check_count, tog;

  sms_port sms_port_inst
  (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .gie_i, .irq_ack_i, .irq_o, .sck_dir_i, .mosi_dir_i, .miso_dir_i, .ss_dir_i,
    .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
    .miso_i(miso_w), .miso_o, .miso_oe_o, .ss_n_i
  );

  sms_spi_peer sms_spi_peer_inst
  (
    .sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(peer_sel_n), .miso_o(peer_miso),
    .cpol_i(peer_cpol), .cpha_i(peer_cpha), .lsb_i(peer_lsb), .tx_i(peer_tx), .rx_o(peer_rx)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(sck_o) tog++;

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask : rc

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_o !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > lim)
      begin
        error_cnt++;
        $display("CHECK FAILED t=%0t wait %h limit %h", $time, n, lim);
        end_of_test();
      end
    end
    @(posedge clk_i);
  endtask : wait_irq

  // Half period of six clocks keeps above the slave sampling limit
  task automatic sbits(input logic cpol, input logic cpha, input logic [7:0] b,
                       input int nb, output logic [7:0] g);
    for (int k = 0; k < nb; k++)
    begin
      tb_sck <= cpol ^ cpha;
      tb_mosi <= b[7 - k];
      repeat (6) @(posedge clk_i);
      g[7 - k] = miso_w;
      tb_sck <= ~(cpol ^ cpha);
      repeat (6) @(posedge clk_i);
    end
    tb_sck <= cpol;
    repeat (8) @(posedge clk_i);
  endtask : sbits

  task automatic t_slave(input logic [1:0] m);
    logic [7:0] g;
    tb_sck <= m[1];
    wr(`SMS_ADDR_CTRL, {4'b0100, m, 2'b11});
    wr(`SMS_ADDR_DATA, 8'h96 ^ {6'h00, m});
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({7'h00, miso_oe_o}, 8'h01);
    sbits(m[1], m[0], 8'h5a + {6'h00, m}, 8, g);
    chk(g, 8'h96 ^ {6'h00, m});
    ss_n_i <= 1'b1;
    tb_mosi <= ~tb_mosi;
    repeat (4) @(posedge clk_i);
    chk({7'h00, miso_oe_o}, 8'h00);
    rc(`SMS_ADDR_STAT, 8'h80);
    rc(`SMS_ADDR_DATA, 8'h5a + {6'h00, m});
  endtask : t_slave

  task automatic t_abort();
    logic [7:0] g;
    sbits(1'b1, 1'b1, 8'hff, 8, g);
    rc(`SMS_ADDR_STAT, 8'h00);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    sbits(1'b1, 1'b1, 8'hff, 3, g);
    ss_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    sbits(1'b1, 1'b1, 8'h4b, 8, g);
    sbits(1'b1, 1'b1, 8'hc3, 8, g);
    ss_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(`SMS_ADDR_STAT, 8'h80);
    rc(`SMS_ADDR_DATA, 8'hc3);
  endtask : t_abort

  task automatic t_master(input int i);
    logic [7:0] tx, ctl;
    logic       cl;
    int         n, k, dv [8];
    dv = '{4, 16, 64, 128, 2, 8, 32, 64};
    k = {29'h0, i[2], i[0], i[1]};
    cl = (i == 5);
    tx = 8'h3c + 8'(i * 37);
    ctl = {1'b1, 1'b1, i[2] ^ i[0], 1'b1, i[1], i[0], i[0], i[1]};
    peer_cpol <= i[1];
    peer_cpha <= i[0];
    peer_lsb <= ctl[5];
    peer_tx <= ~tx;
    tb_sck <= i[1];
    wr(`SMS_ADDR_STAT, {7'h00, i[2]});
    wr(`SMS_ADDR_CTRL, ctl);
    // Let the clock settle at its new idle level before the peer is selected
    @(posedge clk_i);
    chk({6'h00, sck_oe_o, mosi_oe_o}, 8'h03);
    peer_sel_n <= 1'b0;
    @(posedge clk_i);
    tog = 0;
    wr(`SMS_ADDR_DATA, tx);
    if (cl)
      wr(`SMS_ADDR_DATA, 8'hff);
    wait_irq(1100, n);
    chk({7'h00, n >= 8 * dv[k] - 4 && n <= 8 * dv[k] + 6}, 8'h01);
    chk(8'(tog), 8'h10);
    chk({7'h00, sck_o}, {7'h00, ctl[3]});
    chk(peer_rx, tx);
    rc(`SMS_ADDR_STAT, {1'b1, cl, 5'h00, i[2]});
    rc(`SMS_ADDR_DATA, ~tx);
    rc(`SMS_ADDR_STAT, {7'h00, i[2]});
    chk({7'h00, irq_o}, 8'h00);
    peer_sel_n <= 1'b1;
  endtask : t_master

  task automatic t_off();
    wr(`SMS_ADDR_CTRL, 8'h98);
    wr(`SMS_ADDR_DATA, 8'h77);
    tog = 0;
    repeat (40) @(posedge clk_i);
    chk(8'(tog), 8'h00);
    rc(`SMS_ADDR_STAT, 8'h01);
  endtask : t_off

  task automatic t_fault();
    gie_i <= 1'b0;
    ss_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ss_dir_i <= 1'b0;
    wr(`SMS_ADDR_CTRL, 8'hd0);
    repeat (4) @(posedge clk_i);
    ss_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({6'h00, sck_oe_o, mosi_oe_o}, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    gie_i <= 1'b1;
    ss_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    rc(`SMS_ADDR_CTRL, 8'hc0);
    wr(`SMS_ADDR_CTRL, 8'hd0);
    rc(`SMS_ADDR_CTRL, 8'hd0);
  endtask : t_fault

  initial
  begin
    {rst_n_i, wr_i, rd_i, gie_i, irq_ack_i, tb_sck, tb_mosi} = 7'h00;
    {sck_dir_i, mosi_dir_i, miso_dir_i, ss_dir_i} = 4'b0010;
    {ss_n_i, peer_sel_n, peer_cpol, peer_cpha, peer_lsb} = 5'b11000;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    peer_tx = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rc(`SMS_ADDR_CTRL, 8'h00);
    rc(`SMS_ADDR_STAT, 8'h00);
    wr(8'h30, 8'hff);
    rc(8'h30, 8'h00);
    wr(`SMS_ADDR_STAT, 8'hff);
    rc(`SMS_ADDR_STAT, 8'h01);
    wr(`SMS_ADDR_STAT, 8'h00);
    for (int m = 0; m < 4; m++)
      t_slave(2'(m));
    t_abort();
    {sck_dir_i, mosi_dir_i, miso_dir_i, ss_dir_i} <= 4'b1101;
    ss_n_i <= 1'b0;
    gie_i <= 1'b1;
    for (int i = 0; i < 8; i++)
      t_master(i);
    t_off();
    t_fault();
    end_of_test();
  end
endmodule : test_spi_master_slave_port
